// >>> design/bulk_out_pkg.sv
// Package of constants and types for the bulk OUT endpoint 2 receive flag block.
package bulk_out_pkg;

  // --------------------------------------------------------------------------
  // Register map (byte addresses on the AXI4-Lite slave)
  // --------------------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS = 8'h00; // Sticky flags, write one to clear.
  localparam logic [7:0] ADDR_MASK   = 8'h04; // Interrupt mask, one masks.
  localparam logic [7:0] ADDR_LENGTH = 8'h08; // Bytes left to read on the CPU side, read-only.

  // --------------------------------------------------------------------------
  // Field positions in status and mask
  // --------------------------------------------------------------------------
  localparam int BIT_DONE = 0;
  localparam int BIT_NAK  = 1;
  localparam int BIT_NULL = 2;
  localparam int BIT_FULL = 3;
  localparam int NUM_FLAGS = 4;

  localparam logic [3:0]  FLAGS_RST = 4'h0;
  localparam logic [3:0]  MASK_RST  = 4'h0;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Events from the serial engine, one-cycle pulses.
  typedef struct packed {
    logic       out_nak;   // OUT token answered with NAK.
    logic       rx_ok;     // Packet received correctly.
    logic [6:0] rx_len;    // Length of that packet.
  } sie_event_t;

  // Events from the CPU side of the FIFO.
  typedef struct packed {
    logic cpu_read;        // One byte popped from the CPU-side FIFO.
  } cpu_event_t;

endpackage : bulk_out_pkg

// >>> design/bulk_out_ep2_rx_status_flags.sv
// Receive status flags, interrupt and register slave for bulk OUT endpoint 2.
`timescale 1ns/100ps
`default_nettype none

module bulk_out_ep2_rx_status_flags #(
  parameter int LEN_W = 7
) (
  input  wire logic                    i_clk_sys,
  input  wire logic                    i_rst_n,
  input  wire bulk_out_pkg::sie_event_t i_sie,
  input  wire bulk_out_pkg::cpu_event_t i_cpu,
  input  wire logic [7:0]              i_awaddr,
  input  wire logic                    i_awvalid,
  output logic                         o_awready,
  input  wire logic [31:0]             i_wdata,
  input  wire logic [3:0]              i_wstrb,
  input  wire logic                    i_wvalid,
  output logic                         o_wready,
  output logic [1:0]                   o_bresp,
  output logic                         o_bvalid,
  input  wire logic                    i_bready,
  input  wire logic [7:0]              i_araddr,
  input  wire logic                    i_arvalid,
  output logic                         o_arready,
  output logic [31:0]                  o_rdata,
  output logic [1:0]                   o_rresp,
  output logic                         o_rvalid,
  input  wire logic                    i_rready,
  output logic                         o_cpu_has_data,
  output logic                         o_irq
);

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic [3:0]       flags_r;
  logic [3:0]       mask_r;
  logic             sie_full_r;    // Serial-side FIFO holds a packet.
  logic [LEN_W-1:0] sie_len_r;
  logic             cpu_full_r;    // CPU-side FIFO holds a packet.
  logic [LEN_W-1:0] cpu_len_r;     // Bytes left to read on the CPU side.
  logic             null_pend_r;   // Null packet waiting for the CPU side to drain.
  logic [7:0]       awaddr_r;
  logic             aw_have_r;
  logic [31:0]      wdata_r;
  logic [3:0]       wstrb_r;
  logic             w_have_r;

  logic             len0;
  logic             rx_data;
  logic             rx_null;
  logic             cpu_drained;
  logic             toggle;
  logic [3:0]       set_ev;
  logic [3:0]       clr_ev;
  logic             wr_fire;

  // --------------------------------------------------------------------------
  // FIFO ping-pong bookkeeping
  // --------------------------------------------------------------------------
  // Pulses derived from the serial engine and the CPU side.
  assign len0        = (i_sie.rx_len == '0);
  assign rx_data     = i_sie.rx_ok && !len0;
  assign rx_null     = i_sie.rx_ok && len0;
  assign cpu_drained = cpu_full_r && i_cpu.cpu_read && (cpu_len_r == LEN_W'(1));
  // The packet moves to the CPU side whenever that side is free or just emptied.
  assign toggle      = (sie_full_r || rx_data) && (!cpu_full_r || cpu_drained);

  // Tracks occupancy and lengths of both FIFO halves.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      sie_full_r <= 1'b0;
      sie_len_r  <= '0;
      cpu_full_r <= 1'b0;
      cpu_len_r  <= '0;
    end else begin
      if (toggle) begin
        cpu_full_r <= 1'b1;
        cpu_len_r  <= sie_full_r ? sie_len_r : i_sie.rx_len[LEN_W-1:0];
        sie_full_r <= sie_full_r && rx_data;
        sie_len_r  <= i_sie.rx_len[LEN_W-1:0];
      end else begin
        if (rx_data) begin
          sie_full_r <= 1'b1;
          sie_len_r  <= i_sie.rx_len[LEN_W-1:0];
        end
        if (cpu_drained) begin
          cpu_full_r <= 1'b0;
          cpu_len_r  <= '0;
        end else if (cpu_full_r && i_cpu.cpu_read) begin
          cpu_len_r <= cpu_len_r - LEN_W'(1);
        end
      end
    end
  end

  // Holds back a null packet that arrived while the CPU side still had data.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      null_pend_r <= 1'b0;
    end else if (rx_null && cpu_full_r && !cpu_drained) begin
      null_pend_r <= 1'b1;
    end else if (cpu_drained) begin
      null_pend_r <= 1'b0;
    end
  end

  // --------------------------------------------------------------------------
  // Flag events
  // --------------------------------------------------------------------------
  always_comb begin
    set_ev = '0;
    clr_ev = '0;
    set_ev[bulk_out_pkg::BIT_NULL] = (rx_null && (!cpu_full_r || cpu_drained))
                                   || (null_pend_r && cpu_drained);
    set_ev[bulk_out_pkg::BIT_NAK]  = i_sie.out_nak;
    set_ev[bulk_out_pkg::BIT_DONE] = toggle;
    // On a toggle, Full is judged on the occupancy after this cycle, so a toggle that
    // empties the serial side really clears it instead of being outvoted.
    set_ev[bulk_out_pkg::BIT_FULL] = (cpu_full_r && sie_full_r && !toggle)
                                   || (toggle && sie_full_r && rx_data);
    clr_ev[bulk_out_pkg::BIT_DONE] = cpu_drained;
    clr_ev[bulk_out_pkg::BIT_FULL] = toggle;
    if (wr_fire && awaddr_r == bulk_out_pkg::ADDR_STATUS && wstrb_r[0]) begin
      clr_ev = clr_ev | wdata_r[3:0];
    end
  end

  // Sticky flags; a set in the same cycle as a clear wins.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      flags_r <= bulk_out_pkg::FLAGS_RST;
    end else begin
      flags_r <= (flags_r & ~clr_ev) | set_ev;
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite write channel
  // --------------------------------------------------------------------------
  assign wr_fire = aw_have_r && w_have_r && !o_bvalid;

  // Latches address and data in either order, then answers once.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= bulk_out_pkg::RESP_OKAY;
    end else begin
      o_awready <= !aw_have_r && !o_awready && i_awvalid;
      o_wready  <= !w_have_r && !o_wready && i_wvalid;
      if (o_awready && i_awvalid) begin
        aw_have_r <= 1'b1;
        awaddr_r  <= i_awaddr;
      end
      if (o_wready && i_wvalid) begin
        w_have_r <= 1'b1;
        wdata_r  <= i_wdata;
        wstrb_r  <= i_wstrb;
      end
      if (wr_fire) begin
        o_bvalid <= 1'b1;
        o_bresp  <= (awaddr_r == bulk_out_pkg::ADDR_STATUS
                     || awaddr_r == bulk_out_pkg::ADDR_MASK)
                    ? bulk_out_pkg::RESP_OKAY : bulk_out_pkg::RESP_SLVERR;
      end else if (o_bvalid && i_bready) begin
        o_bvalid  <= 1'b0;
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
      end
    end
  end

  // Mask register written through byte lane 0.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      mask_r <= bulk_out_pkg::MASK_RST;
    end else if (wr_fire && awaddr_r == bulk_out_pkg::ADDR_MASK && wstrb_r[0]) begin
      mask_r <= wdata_r[3:0];
    end
  end

  // --------------------------------------------------------------------------
  // AXI4-Lite read channel
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= '0;
      o_rresp   <= bulk_out_pkg::RESP_OKAY;
    end else begin
      o_arready <= !o_rvalid && !o_arready && i_arvalid;
      if (o_arready && i_arvalid) begin
        o_rvalid <= 1'b1;
        o_rresp  <= bulk_out_pkg::RESP_OKAY;
        case (i_araddr)
          bulk_out_pkg::ADDR_STATUS: o_rdata <= {28'h000_0000, flags_r};
          bulk_out_pkg::ADDR_MASK:   o_rdata <= {28'h000_0000, mask_r};
          bulk_out_pkg::ADDR_LENGTH: o_rdata <= {{(32-LEN_W){1'b0}}, cpu_len_r};
          default: begin
            o_rdata <= '0;
            o_rresp <= bulk_out_pkg::RESP_SLVERR;
          end
        endcase
      end else if (o_rvalid && i_rready) begin
        o_rvalid <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Interrupt and status outputs
  // --------------------------------------------------------------------------
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_irq          <= 1'b0;
      o_cpu_has_data <= 1'b0;
    end else begin
      o_irq          <= |(flags_r & ~mask_r);
      o_cpu_has_data <= cpu_full_r;
    end
  end

endmodule // bulk_out_ep2_rx_status_flags

`default_nettype wire

// >>> bench/bulk_host_model.sv
// Behavioural USB host that issues OUT traffic to endpoint 2.
`timescale 1ns/100ps
`default_nettype none
module bulk_host_model (
  input  wire logic                     i_clk_sys,
  output var  bulk_out_pkg::sie_event_t o_sie
);
  // Idle: no token, and a scrambled length so a stale value is never trusted.
  initial o_sie = '{1'b0, 1'b0, 7'h55};
  // One OUT token answered with NAK, or one good packet of len bytes.
  task automatic send(input logic nak, input logic [6:0] len);
    @(posedge i_clk_sys) o_sie <= '{nak, !nak, len};
    @(posedge i_clk_sys) o_sie <= '{1'b0, 1'b0, ~len};
    repeat (2) @(posedge i_clk_sys);
  endtask
endmodule // bulk_host_model
`default_nettype wire

// >>> bench/bulk_out_flags_chk.sv
// Port checker for the endpoint 2 receive flag block.
`timescale 1ns/100ps
`default_nettype none
module bulk_out_flags_chk (
  input wire logic                     i_clk_sys,
  input wire logic                     i_rst_n,
  input wire bulk_out_pkg::sie_event_t i_sie,
  input wire bulk_out_pkg::cpu_event_t i_cpu,
  input wire logic [7:0]               i_awaddr,
  input wire logic                     i_awvalid,
  input wire logic                     o_awready,
  input wire logic [31:0]              i_wdata,
  input wire logic                     o_cpu_has_data,
  input wire logic                     o_irq
);
  logic [3:0] mk_r;
  logic       nul, dat;
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  // Shadow of the mask, so interrupt checks know which flags may pass.
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) mk_r <= 4'h0;
    else if (i_awvalid && o_awready && i_awaddr == bulk_out_pkg::ADDR_MASK) mk_r <= i_wdata[3:0];
  end
  // Null and non-empty packets from the serial engine.
  assign nul = i_sie.rx_ok && i_sie.rx_len == 7'h00;
  assign dat = i_sie.rx_ok && i_sie.rx_len != 7'h00;
  AST_RST_IDLE: assert property ($rose(i_rst_n) |-> !o_irq && !o_cpu_has_data)
    else $error("outputs busy after reset");
  AST_NAK_IRQ: assert property (i_sie.out_nak && !mk_r[1] |-> ##[1:2] o_irq)
    else $error("no irq after nak");
  AST_NULL_IRQ: assert property (nul && !o_cpu_has_data && !mk_r[2] |-> ##[1:2] o_irq)
    else $error("no irq after null packet");
  AST_DONE_IRQ: assert property (dat && !o_cpu_has_data && !mk_r[0] |-> ##[1:3] o_irq)
    else $error("no irq after packet");
  AST_DONE_DATA: assert property (dat && !o_cpu_has_data |-> ##2 o_cpu_has_data)
    else $error("packet not moved to cpu side");
  AST_DATA_HOLD: assert property (o_cpu_has_data && !$past(i_cpu.cpu_read) && !i_cpu.cpu_read
    |=> o_cpu_has_data)
    else $error("cpu side lost data");
  AST_FULL_IRQ: assert property (dat && o_cpu_has_data && !mk_r[3] |-> ##[1:3] o_irq)
    else $error("no irq with both halves full");
  AST_MASK_ALL: assert property ((mk_r == 4'hf)[*3] |-> !o_irq)
    else $error("irq while all masked");
  cover property (nul && o_cpu_has_data);
  cover property (dat && o_cpu_has_data);
  cover property (i_sie.out_nak && mk_r[1]);
endmodule // bulk_out_flags_chk
bind bulk_out_ep2_rx_status_flags bulk_out_flags_chk chk (
  .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_sie(i_sie), .i_cpu(i_cpu),
  .i_awaddr(i_awaddr), .i_awvalid(i_awvalid), .o_awready(o_awready),
  .i_wdata(i_wdata), .o_cpu_has_data(o_cpu_has_data), .o_irq(o_irq));
`default_nettype wire

// >>> bench/bulk_out_ep2_rx_status_flags_tb.sv
// Self-checking bench for the endpoint 2 receive flag block.
`timescale 1ns/100ps
`default_nettype none
module bulk_out_ep2_rx_status_flags_tb;
  localparam logic [7:0] ST = bulk_out_pkg::ADDR_STATUS, MK = bulk_out_pkg::ADDR_MASK;
  localparam logic [7:0] LN = bulk_out_pkg::ADDR_LENGTH;
  localparam logic [1:0] OK = bulk_out_pkg::RESP_OKAY, ER = bulk_out_pkg::RESP_SLVERR;
  logic i_clk_sys, i_rst_n, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, has_data, irq;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  bulk_out_pkg::sie_event_t sie;
  bulk_out_pkg::cpu_event_t cpu;
  int checks, miscompares;
  bulk_out_ep2_rx_status_flags dut (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_sie(sie), .i_cpu(cpu),
    .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
    .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
    .i_rready(rready), .o_cpu_has_data(has_data), .o_irq(irq));
  bulk_host_model host (.i_clk_sys(i_clk_sys), .o_sie(sie));
  // Clock at 200 MHz.
  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Write: address and data offered together, each dropped once taken.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge i_clk_sys) {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    do begin
      @(posedge i_clk_sys);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", {er, 32'h0}, {bresp, 32'h0});
  endtask
  // Read: response code and data are taken at the edge that sees rvalid.
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge i_clk_sys) {araddr, arvalid, rready} <= {a, 2'b11};
    do begin
      @(posedge i_clk_sys);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    chk("read", {er, d}, {rresp, rdata});
  endtask
  // Interrupt level once a flag change has had time to reach it.
  task automatic irq_is(input logic e);
    repeat (3) @(posedge i_clk_sys);
    chk("irq", {33'h0, e}, {33'h0, irq});
  endtask
  // CPU pops n bytes on consecutive cycles.
  task automatic drain(input int n);
    repeat (n) @(posedge i_clk_sys) cpu.cpu_read <= 1'b1;
    @(posedge i_clk_sys) cpu.cpu_read <= 1'b0;
    repeat (2) @(posedge i_clk_sys);
  endtask
  task automatic conclude();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Watchdog: the tests need well under a thousand cycles.
  initial begin
    #50us miscompares++;
    conclude();
  end
  // Test sequence.
  initial begin
    {i_rst_n, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata, cpu, wstrb} = 53'h0_000f;
    repeat (10) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    rd(ST, 32'h0, OK);
    rd(MK, 32'h0, OK);
    host.send(1'b1, 7'h00);
    irq_is(1'b1);
    rd(ST, 32'h2, OK);
    wr(ST, 32'h2, OK);
    host.send(1'b0, 7'h00);
    rd(ST, 32'h4, OK);
    wr(ST, 32'h4, OK);
    $display("nak and null test done");
    host.send(1'b0, 7'h03);
    host.send(1'b0, 7'h00);
    rd(ST, 32'h1, OK);
    chk("has_data", 34'h1, {33'h0, has_data});
    drain(3);
    chk("has_data", 34'h0, {33'h0, has_data});
    rd(ST, 32'h4, OK);
    wr(ST, 32'h4, OK);
    host.send(1'b0, 7'h03);
    host.send(1'b0, 7'h02);
    rd(ST, 32'h9, OK);
    drain(3);
    rd(LN, 32'h2, OK);
    rd(ST, 32'h1, OK);
    drain(2);
    rd(ST, 32'h0, OK);
    $display("delayed null and full test done");
    wr(MK, 32'hf, OK);
    host.send(1'b1, 7'h00);
    irq_is(1'b0);
    wr(MK, 32'h0, OK);
    irq_is(1'b1);
    wr(ST, 32'h2, OK);
    irq_is(1'b0);
    rd(8'h0c, 32'h0, ER);
    wr(LN, 32'h5, ER);
    $display("mask and error test done");
    conclude();
  end
endmodule // bulk_out_ep2_rx_status_flags_tb
`default_nettype wire
